// File: rtl/dcr_top.sv
// Register set and transfer sequencing of a three-channel DMA controller
`timescale 1ns/10ps
module dcr_top
  import dcr_pkg::*;
#(
  parameter int NUM_CH = 3
)
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Register port
  input  wire logic [4:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // Peripheral requests and transfer acknowledge from the bus side
  input  wire logic [2:0]  DREQ_I,
  input  wire logic [2:0]  XFER_ACK_I,
  input  wire logic [2:0]  XFER_ERR_I,
  // Transfer request towards the bus side
  output logic      [2:0]  XFER_REQ_O,
  output logic      [2:0]  XFER_DIR_O,
  output logic      [2:0]  XFER_BURST_O,
  output logic      [2:0]  XFER_WIDE_O,
  output logic      [71:0] XFER_ADDR_O,
  // Interrupt
  output logic             IRQ_O
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] ctl_reg   [NUM_CH];
  logic [23:0] addr_reg  [NUM_CH]; // channel 0 source, 1/2 memory address
  logic [23:0] dst0_reg;
  logic [15:0] cnt_reg   [NUM_CH];
  logic [5:0]  stat_reg;            // bits 2:0 done, 5:3 error
  logic [5:0]  mask_reg;
  logic [15:0] rdata_reg;
  logic        irq_reg;
  logic [2:0]  req_reg;
  logic [2:0]  dir_reg;
  logic [2:0]  burst_reg;
  logic [2:0]  wide_reg;
  logic [71:0] xaddr_reg;

  logic [2:0]  pend;
  logic [2:0]  step;
  logic [2:0]  done;
  logic [2:0]  run;
  logic [2:0]  irq_allow;
  logic [2:0]  flag_clr;
  logic [5:0]  stat_next;
  logic [15:0] rd_next;

  // ****************************************************************
  // Per-channel field decode and request logic
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      logic dir_b;
      logic sense_b;
      logic demand_b;
      logic burst_b;
      logic wide_b;
      logic inc_b;
      logic clr_b;

      // Channel 0 keeps a wider layout with a two-bit direction
      if (g == 0)
      begin : g_c0
        assign dir_b    = ctl_reg[0][DCR_B_C0_DIR_LO]; // see RULE17
        assign sense_b  = ctl_reg[0][2];
        assign demand_b = ctl_reg[0][3];
        assign burst_b  = ctl_reg[0][4];
        assign wide_b   = ctl_reg[0][10];
        assign inc_b    = ctl_reg[0][DCR_B_C0_AUTOINC];
        assign clr_b    = WR_I && ADDR_I == DCR_ADDR_CTL0 && WDATA_I[DCR_B_C0_CLEAR];
      end
      else
      begin : g_c12
        assign dir_b    = ctl_reg[g][DCR_B_DIR];    // see RULE4
        assign sense_b  = ctl_reg[g][DCR_B_SENSE];  // see RULE5
        assign demand_b = ctl_reg[g][DCR_B_DEMAND]; // see RULE6
        assign burst_b  = ctl_reg[g][DCR_B_BURST];  // see RULE7
        assign wide_b   = ctl_reg[g][DCR_B_OPW] | ctl_reg[g][DCR_B_PORTW]; // see RULE8 RULE9
        assign inc_b    = ctl_reg[g][DCR_B_AUTOINC];
        assign clr_b    = WR_I && ADDR_I == 5'(DCR_ADDR_CTL0 + 5'(g))
                          && WDATA_I[DCR_B_FLAG_CLEAR]; // see RULE11
      end

      assign run[g]       = ctl_reg[g][DCR_B_CHAN_RUN]; // see RULE3
      assign irq_allow[g] = ctl_reg[g][DCR_B_IRQ_ALLOW]; // see RULE2
      assign flag_clr[g]  = clr_b;

      dcr_chan u_chan (
        .clk_i         (CLK_I),
        .rst_n_i       (RST_N_I),
        .run_i         (run[g]),
        .sense_level_i (sense_b),
        .demand_i      (demand_b),
        .autoinc_i     (inc_b),
        .wide_i        (wide_b),
        .req_i         (DREQ_I[g]),
        .ack_i         (XFER_ACK_I[g] && req_reg[g]),
        .cnt_zero_i    (cnt_reg[g] == 16'h0001),
        .pend_o        (pend[g]),
        .step_o        (step[g]),
        .done_o        (done[g])
      );

      // Transfer request outputs, registered; a spent count never requests, so it cannot wrap
      always_ff @(posedge CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
        begin
          req_reg[g]   <= 1'b0;
          dir_reg[g]   <= 1'b0;
          burst_reg[g] <= 1'b0;
          wide_reg[g]  <= 1'b0;
        end
        else
        begin
          req_reg[g]   <= pend[g] && !done[g] && cnt_reg[g] != 16'h0000; // see RULE18
          dir_reg[g]   <= dir_b;
          burst_reg[g] <= burst_b;
          wide_reg[g]  <= wide_b;
        end
      end

      // Address presented: channel 0 shows destination when direction set
      always_ff @(posedge CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
          xaddr_reg[g*24 +: 24] <= 24'h000000;
        else if (g == 0 && dir_b)
          xaddr_reg[g*24 +: 24] <= dst0_reg;
        else
          xaddr_reg[g*24 +: 24] <= addr_reg[g];
      end
    end
  endgenerate

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Cleared on reset; clear bit is a strobe and is never stored
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < NUM_CH; i++)
        ctl_reg[i] <= DCR_CTL_RESET; // see RULE1
    end
    else if (WR_I)
    begin
      if (ADDR_I == DCR_ADDR_CTL0)
        ctl_reg[0] <= WDATA_I & DCR_CTL0_MASK; // see RULE17
      if (ADDR_I == DCR_ADDR_CTL1)
        ctl_reg[1] <= WDATA_I & DCR_CTL12_MASK; // see RULE19
      if (ADDR_I == DCR_ADDR_CTL2)
        ctl_reg[2] <= WDATA_I & DCR_CTL12_MASK; // see RULE19
    end
  end

  // ****************************************************************
  // Address and count registers
  // ****************************************************************
  // No reset: contents are undefined until software loads them
  always_ff @(posedge CLK_I) // see RULE16
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      // Step by two for 16-bit operands
      if (step[i])
        addr_reg[i] <= addr_reg[i] + (wide_reg[i] ? 24'h000002 : 24'h000001); // see RULE10
      if (XFER_ACK_I[i] && req_reg[i])
        cnt_reg[i] <= cnt_reg[i] - 16'h0001; // see RULE18
    end
    if (WR_I)
    begin
      case (ADDR_I)
        DCR_ADDR_SRC0_H: addr_reg[0][23:16] <= WDATA_I[7:0];  // see RULE12
        DCR_ADDR_SRC0_L: addr_reg[0][15:0]  <= WDATA_I;       // see RULE12
        DCR_ADDR_DST0_H: dst0_reg[23:16]    <= WDATA_I[7:0];  // see RULE13
        DCR_ADDR_DST0_L: dst0_reg[15:0]     <= WDATA_I;       // see RULE13
        DCR_ADDR_MEM1_H: addr_reg[1][23:16] <= WDATA_I[7:0];  // see RULE14
        DCR_ADDR_MEM1_L: addr_reg[1][15:0]  <= WDATA_I;       // see RULE14
        DCR_ADDR_MEM2_H: addr_reg[2][23:16] <= WDATA_I[7:0];  // see RULE14
        DCR_ADDR_MEM2_L: addr_reg[2][15:0]  <= WDATA_I;       // see RULE14
        DCR_ADDR_CNT0:   cnt_reg[0]         <= WDATA_I;       // see RULE15
        DCR_ADDR_CNT1:   cnt_reg[1]         <= WDATA_I;       // see RULE15
        DCR_ADDR_CNT2:   cnt_reg[2]         <= WDATA_I;       // see RULE15
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Status, mask and interrupt
  // ****************************************************************
  // Set wins over clear so an event in the clearing cycle survives
  always_comb
  begin
    stat_next = stat_reg;
    for (int i = 0; i < NUM_CH; i++)
      if (flag_clr[i])
      begin
        stat_next[i]     = 1'b0; // see RULE11
        stat_next[i + 3] = 1'b0; // see RULE11
      end
    if (WR_I && ADDR_I == DCR_ADDR_STAT)
      stat_next = stat_next & ~WDATA_I[5:0];
    stat_next = stat_next | {XFER_ERR_I & req_reg, done}; // see RULE18
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      stat_reg <= DCR_IRQ_RESET;
    else
      stat_reg <= stat_next;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      mask_reg <= DCR_IRQ_RESET;
    else if (WR_I && ADDR_I == DCR_ADDR_MASK)
      mask_reg <= WDATA_I[5:0];
  end

  // Per-channel allow bit gates both done and error of that channel
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(stat_next & mask_reg & {irq_allow, irq_allow}); // see RULE2
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Unmapped addresses and unused bits read zero
  always_comb
  begin
    case (ADDR_I)
      DCR_ADDR_CTL0:   rd_next = ctl_reg[0];
      DCR_ADDR_CTL1:   rd_next = ctl_reg[1];
      DCR_ADDR_CTL2:   rd_next = ctl_reg[2];
      DCR_ADDR_SRC0_H: rd_next = {8'h00, addr_reg[0][23:16]}; // see RULE19
      DCR_ADDR_SRC0_L: rd_next = addr_reg[0][15:0];
      DCR_ADDR_DST0_H: rd_next = {8'h00, dst0_reg[23:16]};
      DCR_ADDR_DST0_L: rd_next = dst0_reg[15:0];
      DCR_ADDR_MEM1_H: rd_next = {8'h00, addr_reg[1][23:16]};
      DCR_ADDR_MEM1_L: rd_next = addr_reg[1][15:0];
      DCR_ADDR_MEM2_H: rd_next = {8'h00, addr_reg[2][23:16]};
      DCR_ADDR_MEM2_L: rd_next = addr_reg[2][15:0];
      DCR_ADDR_CNT0:   rd_next = cnt_reg[0];
      DCR_ADDR_CNT1:   rd_next = cnt_reg[1];
      DCR_ADDR_CNT2:   rd_next = cnt_reg[2];
      DCR_ADDR_STAT:   rd_next = {10'h000, stat_reg};
      DCR_ADDR_MASK:   rd_next = {10'h000, mask_reg};
      default:         rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_reg <= 16'h0000;
    else if (RD_I)
      rdata_reg <= rd_next;
    else
      rdata_reg <= 16'h0000;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA_O      = rdata_reg;
  assign IRQ_O        = irq_reg;
  assign XFER_REQ_O   = req_reg;
  assign XFER_DIR_O   = dir_reg;
  assign XFER_BURST_O = burst_reg;
  assign XFER_WIDE_O  = wide_reg;
  assign XFER_ADDR_O  = xaddr_reg;

endmodule : dcr_top

// File: rtl/dcr_pkg.sv
// Package of constants and types for the DMA channel register set
//
// Overview of operation
// RULE1 - Channel 1 and 2 control registers are 16 bits, cleared to zero on reset.
// RULE2 - Control bit 0 gates the channel's completion or error interrupt.
// RULE3 - Control bit 1 runs the channel when set, idles it when clear.
// RULE4 - Control bit 2 picks direction: 0 memory to device, 1 device to memory.
// RULE5 - Control bit 3 picks request sensing: 0 edge, 1 level.
// RULE6 - Control bit 4 picks single transfer per request or demand transfer.
// RULE7 - Control bit 5 picks cycle steal or burst bus usage.
// RULE8 - Control bit 6 picks 8-bit or 16-bit operands.
// RULE9 - Control bit 7 picks 8-bit or 16-bit device port.
// RULE10 - Control bit 8 makes the memory address count up after each transfer.
// RULE11 - Writing one to control bit 9 clears that channel's completion and error flags.
// RULE12 - Channel 0 source address is 24 bits in high and low words, not reset.
// RULE13 - Channel 0 destination address is 24 bits in the same layout, not reset.
// RULE14 - Channels 1 and 2 each hold a 24-bit memory address, not reset.
// RULE15 - Each channel has a 16-bit transfer count, not reset.
// RULE16 - Software loads address and count before enabling a channel.
// RULE17 - Channel 0 control holds the same kinds of fields, with two-bit direction.
// RULE18 - Count decrements per completed transfer; reaching zero signals completion.
// RULE19 - Unused upper control bits and address bits above 23 read zero.
package dcr_pkg;

  // ****************************************************************
  // Register offsets (word addresses)
  // ****************************************************************
  localparam logic [4:0] DCR_ADDR_CTL0   = 5'h00;
  localparam logic [4:0] DCR_ADDR_CTL1   = 5'h01;
  localparam logic [4:0] DCR_ADDR_CTL2   = 5'h02;
  localparam logic [4:0] DCR_ADDR_SRC0_H = 5'h04;
  localparam logic [4:0] DCR_ADDR_SRC0_L = 5'h05;
  localparam logic [4:0] DCR_ADDR_DST0_H = 5'h06;
  localparam logic [4:0] DCR_ADDR_DST0_L = 5'h07;
  localparam logic [4:0] DCR_ADDR_MEM1_H = 5'h08;
  localparam logic [4:0] DCR_ADDR_MEM1_L = 5'h09;
  localparam logic [4:0] DCR_ADDR_MEM2_H = 5'h0a;
  localparam logic [4:0] DCR_ADDR_MEM2_L = 5'h0b;
  localparam logic [4:0] DCR_ADDR_CNT0   = 5'h0c;
  localparam logic [4:0] DCR_ADDR_CNT1   = 5'h0d;
  localparam logic [4:0] DCR_ADDR_CNT2   = 5'h0e;
  localparam logic [4:0] DCR_ADDR_STAT   = 5'h10;
  localparam logic [4:0] DCR_ADDR_MASK   = 5'h11;

  // ****************************************************************
  // Field positions of channel 1/2 control
  // ****************************************************************
  localparam int DCR_B_IRQ_ALLOW  = 0;
  localparam int DCR_B_CHAN_RUN   = 1;
  localparam int DCR_B_DIR        = 2;
  localparam int DCR_B_SENSE      = 3;
  localparam int DCR_B_DEMAND     = 4;
  localparam int DCR_B_BURST      = 5;
  localparam int DCR_B_OPW        = 6;
  localparam int DCR_B_PORTW      = 7;
  localparam int DCR_B_AUTOINC    = 8;
  localparam int DCR_B_FLAG_CLEAR = 9;
  // Channel 0 control: fields up to bit 12 stored, bit 13 is the clear
  localparam int DCR_B_C0_DIR_LO  = 5;
  localparam int DCR_B_C0_AUTOINC = 12;
  localparam int DCR_B_C0_CLEAR   = 13;

  localparam logic [15:0] DCR_CTL12_MASK = 16'h01ff;
  localparam logic [15:0] DCR_CTL0_MASK  = 16'h1fff;
  localparam logic [15:0] DCR_CTL_RESET  = 16'h0000;
  localparam logic [7:0]  DCR_ADDR_HI_MASK = 8'hff;
  localparam logic [5:0]  DCR_IRQ_RESET  = 6'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } dcr_bus_t;

  typedef struct packed {
    logic        req;
    logic        ack;
    logic [23:0] addr;
    logic        dir;
    logic        wide;
  } dcr_xfer_t;

endpackage : dcr_pkg

// File: rtl/dcr_chan.sv
// One DMA channel's request sensing, completion and address stepping
`timescale 1ns/10ps
module dcr_chan
  import dcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Configuration
  input  wire logic        run_i,
  input  wire logic        sense_level_i,
  input  wire logic        demand_i,
  input  wire logic        autoinc_i,
  input  wire logic        wide_i,
  // Peripheral request and transfer acknowledge
  input  wire logic        req_i,
  input  wire logic        ack_i,
  input  wire logic        cnt_zero_i,
  // Transfer request and completion event
  output logic             pend_o,
  output logic             step_o,
  output logic             done_o
);

  logic req_d_reg;
  logic pend_reg;

  // ****************************************************************
  // Request sensing
  // ****************************************************************
  // Previous request level, for edge mode
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_d_reg <= 1'b0;
    else
      req_d_reg <= req_i;
  end

  // Edge mode latches one pending request; level or demand follows the pin
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pend_reg <= 1'b0;
    else if (!run_i)
      pend_reg <= 1'b0; // see RULE3
    else if (!sense_level_i && req_i && !req_d_reg)
      pend_reg <= 1'b1; // see RULE5
    else if (ack_i)
      pend_reg <= 1'b0;
  end

  // Level or demand requests persist while the pin stays high
  assign pend_o = run_i && (pend_reg || ((sense_level_i || demand_i) && req_i)); // see RULE6
  // Step the memory address only when auto increment is on
  assign step_o = ack_i && autoinc_i; // see RULE10
  // Completion when the last transfer is acknowledged
  assign done_o = ack_i && cnt_zero_i; // see RULE18

  // Width matters only to the step size and XFER_WIDE_O, both handled by the parent
  logic unused_wide;
  assign unused_wide = wide_i;

endmodule : dcr_chan

// File: sim/dcr_top_checker.sv
// Concurrent checks on the ports of the DMA channel register set
`timescale 1ns/10ps
module dcr_top_checker
  import dcr_pkg::*;
#(
  parameter int NUM_CH = 3
)
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Register port
  input  wire logic [4:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [15:0] RDATA_O,
  // Transfer link
  input  wire logic [2:0]  DREQ_I,
  input  wire logic [2:0]  XFER_ACK_I,
  input  wire logic [2:0]  XFER_ERR_I,
  input  wire logic [2:0]  XFER_REQ_O,
  input  wire logic [2:0]  XFER_DIR_O,
  input  wire logic [2:0]  XFER_BURST_O,
  input  wire logic [2:0]  XFER_WIDE_O,
  input  wire logic [71:0] XFER_ADDR_O,
  // Interrupt
  input  wire logic        IRQ_O
);
  logic [15:0] ctl1_reg;
  logic [15:0] ctl2_reg;
  logic [23:0] addr1_reg;
  logic [23:0] step1;
  logic        cause;
  // Shadow of control as software wrote it
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctl1_reg <= DCR_CTL_RESET;
      ctl2_reg <= DCR_CTL_RESET;
    end
    else if (WR_I && ADDR_I == DCR_ADDR_CTL1)
      ctl1_reg <= WDATA_I & DCR_CTL12_MASK;
    else if (WR_I && ADDR_I == DCR_ADDR_CTL2)
      ctl2_reg <= WDATA_I & DCR_CTL12_MASK;
  end
  // Address seen at each ack, not reset as it is only read after an ack
  always_ff @(posedge CLK_I)
  begin
    if (XFER_ACK_I[1])
      addr1_reg <= XFER_ADDR_O[47:24];
  end
  // Expected step and possible interrupt causes
  assign step1 = !ctl1_reg[8] ? 24'h0 : (ctl1_reg[6] | ctl1_reg[7]) ? 24'h2 : 24'h1;
  assign cause = (|XFER_ACK_I) | (|XFER_ERR_I) | WR_I;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_ctl1_stop;
    WR_I && ADDR_I == DCR_ADDR_CTL1 && !WDATA_I[DCR_B_CHAN_RUN];
  endsequence
  sequence s_ack1;
    XFER_ACK_I[1] && XFER_REQ_O[1];
  endsequence

  a_rdata_after_read: assert property (RDATA_O != 16'h0000 |-> $past(RD_I))
    else $error("read data outside read cycle");
  a_ctl1_read_back: assert property (RD_I && ADDR_I == DCR_ADDR_CTL1 |=>
    RDATA_O == $past(ctl1_reg)) else $error("control read mismatch");
  a_unmapped_reads_zero: assert property (RD_I && ADDR_I == 5'h1f |=>
    RDATA_O == 16'h0000) else $error("unmapped read not zero");
  a_req_needs_dreq: assert property ($rose(XFER_REQ_O[1]) |->
    $past(DREQ_I[1]) || $past(DREQ_I[1], 2)) else $error("request without peripheral");
  a_stop_drops_req: assert property (s_ctl1_stop |-> ##[1:2] !XFER_REQ_O[1])
    else $error("request stays after stop");
  // Mode outputs are registered, so they follow control one cycle late
  a_mode1_outputs: assert property (XFER_REQ_O[1] |->
    XFER_DIR_O[1] == $past(ctl1_reg[2]) && XFER_BURST_O[1] == $past(ctl1_reg[5])
    && XFER_WIDE_O[1] == $past(ctl1_reg[6] | ctl1_reg[7]))
    else $error("ch1 mode mismatch");
  a_mode2_outputs: assert property (XFER_REQ_O[2] |->
    XFER_DIR_O[2] == $past(ctl2_reg[2]) && XFER_BURST_O[2] == $past(ctl2_reg[5])
    && XFER_WIDE_O[2] == $past(ctl2_reg[6] | ctl2_reg[7]))
    else $error("ch2 mode mismatch");
  a_addr_step_size: assert property (s_ack1 |-> ##[1:2]
    XFER_ADDR_O[47:24] == addr1_reg + step1) else $error("address step wrong");
  a_irq_has_cause: assert property ($rose(IRQ_O) |-> $past(cause) || $past(cause, 2))
    else $error("interrupt without cause");
endmodule : dcr_top_checker

bind dcr_top dcr_top_checker #(.NUM_CH(NUM_CH)) u_dcr_top_checker
(
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .DREQ_I(DREQ_I), .XFER_ACK_I(XFER_ACK_I),
  .XFER_ERR_I(XFER_ERR_I), .XFER_REQ_O(XFER_REQ_O), .XFER_DIR_O(XFER_DIR_O),
  .XFER_BURST_O(XFER_BURST_O), .XFER_WIDE_O(XFER_WIDE_O), .XFER_ADDR_O(XFER_ADDR_O),
  .IRQ_O(IRQ_O)
);

// File: sim/dcr_periph_model.sv
// Peripheral and bus-side model: raises requests, answers transfers
`timescale 1ns/10ps
module dcr_periph_model
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Commands from the bench
  input  wire logic [2:0] dreq_cmd_i,
  input  wire logic [2:0] err_cmd_i,
  input  wire logic [3:0] ack_wait_i,
  // Link to the block
  input  wire logic [2:0] req_i,
  output logic      [2:0] dreq_o,
  output logic      [2:0] ack_o,
  output logic      [2:0] err_o
);
  logic [2:0][3:0] wait_reg;
  // Requests follow the bench directly
  assign dreq_o = dreq_cmd_i;
  // One answer pulse per wait, then a one-cycle gap before the next answer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o    <= 3'h0;
      err_o    <= 3'h0;
      wait_reg <= '0;
    end
    else
      for (int i = 0; i < 3; i++)
      begin
        if (req_i[i] && !ack_o[i] && !err_o[i] && wait_reg[i] >= ack_wait_i)
        begin
          ack_o[i]    <= !err_cmd_i[i];
          err_o[i]    <= err_cmd_i[i];
          wait_reg[i] <= 4'h0;
        end
        else
        begin
          ack_o[i]    <= 1'b0;
          err_o[i]    <= 1'b0;
          wait_reg[i] <= req_i[i] ? wait_reg[i] + 4'h1 : 4'h0;
        end
      end
  end
endmodule : dcr_periph_model

// File: sim/dcr_top_tb_top.sv
// Self-checking bench for the DMA channel register set
`timescale 1ns/10ps
module dcr_top_tb_top;
  import dcr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0]  dreq_cmd = 3'h0;
  logic [2:0]  err_cmd = 3'h0;
  logic [3:0]  ack_wait = 4'h0;
  logic [2:0]  dreq, ack, err, req, dir, burst, wide;
  logic [71:0] xaddr;
  logic        irq;
  int          err_count = 0;
  int          n_compared = 0;

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  dcr_top u_dcr_top (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DREQ_I(dreq), .XFER_ACK_I(ack),
    .XFER_ERR_I(err), .XFER_REQ_O(req), .XFER_DIR_O(dir), .XFER_BURST_O(burst),
    .XFER_WIDE_O(wide), .XFER_ADDR_O(xaddr), .IRQ_O(irq));
  dcr_periph_model u_dcr_periph_model (.clk_i(clk), .rst_n_i(rst_n),
    .dreq_cmd_i(dreq_cmd), .err_cmd_i(err_cmd), .ack_wait_i(ack_wait), .req_i(req),
    .dreq_o(dreq), .ack_o(ack), .err_o(err));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_reg
  task automatic wait_req(input int ch, input logic lvl);
    for (int i = 0; i < 40 && req[ch] !== lvl; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({23'h0, req[ch]}, {23'h0, lvl});
  endtask : wait_req
  task automatic pulse(input int ch);
    @(posedge clk);
    dreq_cmd[ch] <= 1'b1;
    @(posedge clk);
    dreq_cmd[ch] <= 1'b0;
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk({21'h0, req}, 24'h0);
    rd_reg(DCR_ADDR_CTL1, 16'h0000);
    rd_reg(DCR_ADDR_CTL2, 16'h0000);
    rd_reg(DCR_ADDR_STAT, 16'h0000);
  endtask : t_reset
  task automatic t_regs;
    logic [4:0]  a [14] = '{DCR_ADDR_CTL0, DCR_ADDR_CTL1, DCR_ADDR_CTL2, DCR_ADDR_SRC0_H,
      DCR_ADDR_SRC0_L, DCR_ADDR_DST0_H, DCR_ADDR_DST0_L, DCR_ADDR_MEM1_H,
      DCR_ADDR_MEM1_L, DCR_ADDR_MEM2_H, DCR_ADDR_MEM2_L, DCR_ADDR_CNT0,
      DCR_ADDR_CNT1, DCR_ADDR_CNT2};
    logic [15:0] m [14] = '{16'h1fff, 16'h01ff, 16'h01ff, 16'h00ff, 16'hffff, 16'h00ff,
      16'hffff, 16'h00ff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] p [3] = '{16'hffff, 16'h5a5a, 16'h0000};
    foreach (p[j])
      foreach (a[i])
      begin
        wr_reg(a[i], p[j]);
        rd_reg(a[i], p[j] & m[i]);
      end
    wr_reg(5'h1f, 16'hffff);
    rd_reg(5'h1f, 16'h0000);
  endtask : t_regs
  // Edge-sensed single transfers, count runs out, flag clear
  task automatic t_single;
    wr_reg(DCR_ADDR_MEM1_H, 16'h0012);
    wr_reg(DCR_ADDR_MEM1_L, 16'h3456);
    wr_reg(DCR_ADDR_CNT1, 16'h0002);
    wr_reg(DCR_ADDR_MASK, 16'h0002);
    wr_reg(DCR_ADDR_CTL1, 16'h0103);
    pulse(1);
    wait_req(1, 1'b1);
    chk(xaddr[47:24], 24'h123456);
    wait_req(1, 1'b0);
    chk(xaddr[47:24], 24'h123457);
    rd_reg(DCR_ADDR_CNT1, 16'h0001);
    chk({23'h0, irq}, 24'h0);
    pulse(1);
    wait_req(1, 1'b1);
    wait_req(1, 1'b0);
    rd_reg(DCR_ADDR_CNT1, 16'h0000);
    rd_reg(DCR_ADDR_STAT, 16'h0002);
    chk({23'h0, irq}, 24'h1);
    wr_reg(DCR_ADDR_CTL1, 16'h0303);
    rd_reg(DCR_ADDR_STAT, 16'h0000);
    chk({23'h0, irq}, 24'h0);
  endtask : t_single
  // Level-sensed demand burst, wide, device to memory, slow answers
  task automatic t_demand;
    wr_reg(DCR_ADDR_MEM2_H, 16'h0000);
    wr_reg(DCR_ADDR_MEM2_L, 16'h0010);
    wr_reg(DCR_ADDR_CNT2, 16'h0003);
    wr_reg(DCR_ADDR_MASK, 16'h0004);
    wr_reg(DCR_ADDR_CTL2, 16'h017e);
    ack_wait     <= 4'h3;
    dreq_cmd[2] <= 1'b1;
    wait_req(2, 1'b1);
    chk({15'h0, dir, burst, wide}, {15'h0, 9'h124});
    wait_req(2, 1'b0);
    // Presented address follows the last step one cycle later
    @(posedge clk);
    dreq_cmd[2] <= 1'b0;
    #1;
    chk(xaddr[71:48], 24'h000016);
    rd_reg(DCR_ADDR_STAT, 16'h0004);
    chk({23'h0, irq}, 24'h0);
    wr_reg(DCR_ADDR_CTL2, 16'h017f);
    rd_reg(DCR_ADDR_CNT2, 16'h0000);
    chk({23'h0, irq}, 24'h1);
    wr_reg(DCR_ADDR_STAT, 16'h0004);
    rd_reg(DCR_ADDR_STAT, 16'h0000);
    chk({23'h0, irq}, 24'h0);
  endtask : t_demand
  // Error in mid-run, stop, then error flag clear
  task automatic t_error;
    wr_reg(DCR_ADDR_CNT1, 16'h0100);
    wr_reg(DCR_ADDR_CTL1, 16'h000b);
    err_cmd[1]  <= 1'b1;
    dreq_cmd[1] <= 1'b1;
    wait_req(1, 1'b1);
    // Give the slow answer time to report the error
    repeat (6) @(posedge clk);
    rd_reg(DCR_ADDR_STAT, 16'h0010);
    wr_reg(DCR_ADDR_CTL1, 16'h0009);
    wait_req(1, 1'b0);
    wr_reg(DCR_ADDR_CTL1, 16'h0208);
    err_cmd[1]  <= 1'b0;
    dreq_cmd[1] <= 1'b0;
    rd_reg(DCR_ADDR_STAT, 16'h0000);
    chk({21'h0, req}, 24'h0);
  endtask : t_error

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // Main sequence after a 20-cycle reset
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_single;
    t_demand;
    t_error;
    stop_test;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule : dcr_top_tb_top
